// ---- core/adc_conversion_control.sv ----
// module: control, channel select and result registers around a 10-bit converter core
//
// Functional notes
// - a write to the low result register while idle starts a conversion whatever the data, which is stored; a write while busy starts none
// - continuous bit clear: one conversion per start, then idle
// - continuous bit set, trigger disabled: new conversion begins at each completion
// - clearing continuous mid-conversion finishes it and starts no more
// - trigger enabled, not continuous: start pin falling edge starts one conversion
// - start pin sampled once per cycle; edge is high sample then low sample
// - trigger enabled and continuous: convert continuously while start pin low
// - before any conversion since reset, that mode needs a falling edge first
// - start pin high again stops new starts, running conversion completes
// - busy flag at main control bit 4, set by hardware, read-only
// - every completion sets done flag at interrupt request bit 0
// - low three select bits are one store seen in both control registers
// - channel register writes all four bits; main register only low three
// - 4-bit field picks one of 15 inputs, top bit chooses second port
// - result left justified: msb at high bit 7, lsb at low bit 6
// - results hold until next completion; software reads and writes them
// - high result register is full read-write storage
// - analog pins stay readable as digital inputs at all times
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module adc_conversion_control
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  input wire logic external_start_pin,
  input wire logic [7:0] port7_pins,
  input wire logic [6:0] port8_pins,
  input wire logic core_done,
  input wire logic [9:0] core_result,
  output logic conv_start_q,
  output logic [3:0] channel_q,
  output logic [14:0] input_select_q,
  output logic irq_q
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ext_en_q;
  logic cont_q;
  logic [1:0] main_spare_q;
  logic [3:0] chan_spare_q;
  logic busy_q;
  logic seen_conv_q;
  logic [7:0] res_high_q;
  logic [7:0] res_low_q;
  logic done_flag_q;
  logic done_en_q;
  logic [14:0] pins_s1_q;
  logic [14:0] pins_s2_q;
  logic [14:0] pins_s3_q;
  logic [14:0] pins_q;
  logic pin_level;
  logic pin_fall;
  logic wr_main;
  logic wr_chan;
  logic wr_low;
  logic ext_start;
  logic start_idle;
  logic finish;
  logic restart;
  logic [3:0] channel_d;

  assign wr_main = wr && (addr == OFF_CONTROL_MAIN);
  assign wr_chan = wr && (addr == OFF_CHANNEL_CONTROL);
  assign wr_low = wr && (addr == OFF_RESULT_LOW);
  assign finish = busy_q && core_done;

  // ----------------------------------------------------------------
  // start pin sampling
  // ----------------------------------------------------------------
  start_pin_sampler u_start_pin (
    .clk(clk),
    .rst(rst),
    .pin(external_start_pin),
    .level_q(pin_level),
    .fall_q(pin_fall)
  );

  // ----------------------------------------------------------------
  // start decisions
  // ----------------------------------------------------------------
  // external start: edge in single mode, low level in continuous mode,
  // but a level alone is not enough until one conversion has happened
  always_comb begin
    if (!ext_en_q) begin
      ext_start = 1'b0;
    end else if (!cont_q) begin
      ext_start = pin_fall;
    end else begin
      ext_start = pin_fall || (seen_conv_q && !pin_level);
    end
  end

  // a start from idle; a start while busy is dropped
  assign start_idle = !busy_q && (wr_low || ext_start);

  // at completion, chain on only while continuous is still set; with the
  // trigger enabled the pin must also still be low
  assign restart = finish && cont_q && (!ext_en_q || !pin_level);

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // busy rises with each start and falls at a completion without restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (start_idle) begin
      busy_q <= 1'b1;
    end else if (finish && !restart) begin
      busy_q <= 1'b0;
    end
  end

  // one-cycle start pulse toward the converter core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= start_idle || restart;
    end
  end

  // remembers that a conversion has completed since reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_conv_q <= 1'b0;
    end else if (finish) begin
      seen_conv_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mode bits and the unused storage bits of both control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_en_q <= RST_CONTROL_MAIN[BIT_EXT_ENABLE];
      cont_q <= RST_CONTROL_MAIN[BIT_CONT_MODE];
      main_spare_q <= RST_CONTROL_MAIN[7:6];
      chan_spare_q <= RST_CHANNEL_CONTROL[7:4];
    end else begin
      if (wr_main) begin
        ext_en_q <= wdata[BIT_EXT_ENABLE];
        cont_q <= wdata[BIT_CONT_MODE];
        main_spare_q <= wdata[7:6];
      end
      if (wr_chan) begin
        chan_spare_q <= wdata[7:4];
      end
    end
  end

  // one channel store; the main register reaches only its low three bits
  always_comb begin
    channel_d = channel_q;
    if (wr_chan) begin
      channel_d = wdata[3:0];
    end else if (wr_main) begin
      channel_d = {channel_q[BIT_PORT_SELECT], wdata[2:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_q <= RST_CHANNEL_CONTROL[3:0];
    end else begin
      channel_q <= channel_d;
    end
  end

  // one-hot input select; code 4'hF selects nothing
  genvar gi;
  generate
    for (gi = 0; gi < INPUT_COUNT; gi++) begin : g_sel
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          input_select_q[gi] <= (RST_CHANNEL_CONTROL[3:0] == 4'(gi));
        end else begin
          input_select_q[gi] <= (channel_d == 4'(gi));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // completion overwrites; software writes otherwise. the core's result
  // wins a same-cycle clash so a finished conversion is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_high_q <= RST_RESULT;
      res_low_q <= RST_RESULT;
    end else begin
      if (finish) begin
        res_high_q <= core_result[9:2];
        res_low_q <= {core_result[1:0], 6'h00};
      end else begin
        if (wr && addr == OFF_RESULT_HIGH) begin
          res_high_q <= wdata;
        end
        if (wr_low) begin
          res_low_q <= wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // completion flag and request
  // ----------------------------------------------------------------
  // software clears by writing zero; a completion in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_flag_q <= 1'b0;
    end else if (finish) begin
      done_flag_q <= 1'b1;
    end else if (wr && addr == OFF_IRQ_REQUEST && !wdata[BIT_DONE_FLAG]) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (wr && addr == OFF_IRQ_ENABLE) begin
        done_en_q <= wdata[BIT_DONE_ENABLE];
      end
      irq_q <= done_flag_q && done_en_q;
    end
  end

  // ----------------------------------------------------------------
  // digital view of the analog pins
  // ----------------------------------------------------------------
  // independent of the converter, so sampling never hides the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_s1_q <= 15'h0000;
      pins_s2_q <= 15'h0000;
      pins_s3_q <= 15'h0000;
    end else begin
      pins_s1_q <= {port8_pins, port7_pins};
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  generate
    for (gi = 0; gi < INPUT_COUNT; gi++) begin : g_pin
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pins_q[gi] <= 1'b0;
        end else if (pins_s2_q[gi] == pins_s3_q[gi]) begin
          pins_q[gi] <= pins_s3_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data stand one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        OFF_CONTROL_MAIN: rdata_q <= {main_spare_q, ext_en_q, busy_q, cont_q,
                                      channel_q[2:0]};
        OFF_CHANNEL_CONTROL: rdata_q <= {chan_spare_q, channel_q};
        OFF_RESULT_HIGH: rdata_q <= res_high_q;
        OFF_RESULT_LOW: rdata_q <= res_low_q;
        OFF_IRQ_REQUEST: rdata_q <= {7'h00, done_flag_q};
        OFF_IRQ_ENABLE: rdata_q <= {7'h00, done_en_q};
        OFF_PORT7_IN: rdata_q <= pins_q[7:0];
        OFF_PORT8_IN: rdata_q <= {1'b0, pins_q[14:8]};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_write_low_start: assert property (
    (wr_low && !busy_q) |=> conv_start_q && busy_q)
    else $error("low result write did not start a conversion");

  a_single_mode_stop: assert property (
    (finish && !cont_q) |=> !busy_q && !conv_start_q)
    else $error("single mode did not go idle after completion");

  a_cont_mode_chain: assert property (
    (finish && cont_q && !ext_en_q) |=> conv_start_q && busy_q)
    else $error("continuous mode did not chain a conversion");

  a_cont_cleared_end: assert property (
    (busy_q && !cont_q && !wr_main) ##1 (core_done && !cont_q) |=> !conv_start_q)
    else $error("conversion chained after continuous bit cleared");

  a_ext_edge_start: assert property (
    (!busy_q && ext_en_q && !cont_q && pin_fall) |=> conv_start_q ##1 !conv_start_q)
    else $error("external edge did not start exactly one conversion");

  a_ext_level_run: assert property (
    (!busy_q && ext_en_q && cont_q && seen_conv_q && !pin_level) |=> conv_start_q)
    else $error("low start pin did not start continuous conversion");

  a_first_needs_edge: assert property (
    (!busy_q && !seen_conv_q && ext_en_q && cont_q && !pin_fall && !wr_low)
      |=> !conv_start_q)
    else $error("level started conversion before any since reset");

  a_ext_pin_high_stop: assert property (
    (finish && ext_en_q && pin_level) |=> !busy_q)
    else $error("conversion chained with start pin high");

  a_busy_with_start: assert property (
    conv_start_q |-> busy_q)
    else $error("start pulse without busy flag");

  a_done_flag_set: assert property (
    finish |=> done_flag_q ##1 (done_flag_q || $past(wr)))
    else $error("completion did not set done flag");

  a_main_write_low_bits: assert property (
    (wr_main) |=> channel_q == {$past(channel_q[3]), $past(wdata[2:0])})
    else $error("main register write disturbed port select bit");

  a_result_justified: assert property (
    finish |=> res_high_q == $past(core_result[9:2]) && res_low_q[5:0] == 6'h00)
    else $error("result not stored left justified");

  a_irq_needs_enable: assert property (
    irq_q |-> $past(done_flag_q) && $past(done_en_q))
    else $error("request raised without flag and enable");

endmodule : adc_conversion_control

// ---- inc/adc_pkg.sv ----
// package: register map, field positions and reset values of the converter control
package adc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL_MAIN = 8'hD8;
  localparam logic [7:0] OFF_CHANNEL_CONTROL = 8'hDC;
  localparam logic [7:0] OFF_RESULT_HIGH = 8'hD9;
  localparam logic [7:0] OFF_RESULT_LOW = 8'hDA;
  localparam logic [7:0] OFF_IRQ_REQUEST = 8'hC0;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h9A;
  localparam logic [7:0] OFF_PORT7_IN = 8'hDB;
  localparam logic [7:0] OFF_PORT8_IN = 8'hDD;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT_ENABLE = 5;
  localparam int BIT_BUSY = 4;
  localparam int BIT_CONT_MODE = 3;
  localparam int BIT_PORT_SELECT = 3;
  localparam int BIT_DONE_FLAG = 0;
  localparam int BIT_DONE_ENABLE = 0;
  localparam int RESULT_BITS = 10;
  localparam int INPUT_COUNT = 15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_MAIN = 8'h00;
  localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h40;
  localparam logic [7:0] RST_RESULT = 8'h00;

endpackage : adc_pkg

// ---- core/start_pin_sampler.sv ----
// module: three-stage sampler and falling-edge detector for the external start pin
`timescale 1ns/1ps

module start_pin_sampler
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level_q,
  output logic fall_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [1:0] fill_q;
  logic primed_q;

  // ----------------------------------------------------------------
  // synchroniser, one sample per machine cycle
  // ----------------------------------------------------------------
  // reset high, the idle level of the start pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // counts edges until stage three holds a real pin sample; the reset value
  // of the stages is made up and must never pass for a high sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else if (fill_q != 2'h3) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // set once the accepted level comes from the pin itself, so a pin held
  // low through reset is never taken for a falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primed_q <= 1'b0;
    end else if (fill_q == 2'h3 && s2_q == s3_q) begin
      primed_q <= 1'b1;
    end
  end

  // accepted level moves only when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  // edge: high in one accepted sample, low in the next
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= primed_q && level_q && (s2_q == s3_q) && !s3_q;
    end
  end

  a_fall_edge_order: assert property (@(posedge clk) disable iff (rst)
    fall_q |-> !level_q && $past(level_q))
    else $error("fall pulse without high-then-low samples");

endmodule : start_pin_sampler

// ---- tb/adc_core_model.sv ----
// converter core stand-in: answers every start with a done pulse and a result
`timescale 1ns/1ps

module adc_core_model
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] channel,
  input wire logic slow,
  output logic done,
  output logic [9:0] result
);
  logic [4:0] left_q;
  logic [5:0] seq_q;

  // ----------------------------------------------------------------
  // conversion timer
  // ----------------------------------------------------------------
  // result toggles outside the done cycle so a stale value never passes for a fresh one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= 5'h00;
      seq_q <= 6'h00;
      done <= 1'b0;
      result <= 10'h155;
    end else begin
      done <= 1'b0;
      result <= ~result;
      if (start) begin
        left_q <= slow ? 5'h0C : 5'h03; // prompt or slow answer
      end else if (left_q == 5'h01) begin
        left_q <= 5'h00;
        done <= 1'b1;
        result <= {channel, seq_q};
        seq_q <= seq_q + 6'h01;
      end else if (left_q != 5'h00) begin
        left_q <= left_q - 5'h01;
      end
    end
  end

endmodule : adc_core_model

// ---- tb/tb_adc_conversion_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps

module tb_adc_conversion_control;
  import adc_pkg::*;
  logic clk, rst, wr, rd, pin, slow, core_done, conv_start_q, irq_q;
  logic [7:0] addr, wdata, rdata_q, port7_pins, r;
  logic [6:0] port8_pins;
  logic [9:0] core_result, last_res;
  logic [3:0] channel_q;
  logic [14:0] input_select_q;
  int num_errors, check_count, start_cnt, done_cnt, s;

  adc_conversion_control u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .external_start_pin(pin), .port7_pins(port7_pins),
    .port8_pins(port8_pins), .core_done(core_done), .core_result(core_result),
    .conv_start_q(conv_start_q), .channel_q(channel_q), .input_select_q(input_select_q),
    .irq_q(irq_q));

  adc_core_model u_core (.clk(clk), .rst(rst), .start(conv_start_q), .channel(channel_q),
    .slow(slow), .done(core_done), .result(core_result));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // link monitor
  // ----------------------------------------------------------------
  // counts starts and completions so idle and chaining can be judged
  always @(posedge clk) begin
    if (conv_start_q === 1'b1) start_cnt++;
    if (core_done === 1'b1) begin
      done_cnt++;
      last_res = core_result;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask : rd_reg

  // a chained start lands one edge after its completion, so idle must hold a while
  task automatic wait_idle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 400 && quiet < 4; i++) begin
      @(posedge clk);
      quiet = (start_cnt == done_cnt) ? quiet + 1 : 0;
    end
  endtask : wait_idle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    rd_reg(OFF_CONTROL_MAIN, r);
    check(16'(r), 16'(RST_CONTROL_MAIN), "main reset");
    rd_reg(OFF_CHANNEL_CONTROL, r);
    check(16'(r), 16'(RST_CHANNEL_CONTROL), "channel reset");
    rd_reg(8'h10, r);
    check(16'(r), 16'h0000, "unmapped read");
    check(16'(input_select_q), 16'h0001, "select reset");
    rd_reg(OFF_PORT7_IN, r);
    check(16'(r), 16'h00A6, "port7 digital");
    rd_reg(OFF_PORT8_IN, r);
    check(16'(r), 16'h0035, "port8 digital");
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_edge_needed();
    wr_reg(OFF_CONTROL_MAIN, 8'h28);
    cycles(30);
    check(16'(start_cnt), 16'h0000, "low level started");
    pin <= 1'b1;
    cycles(6);
    pin <= 1'b0;
    cycles(10);
    check(16'(start_cnt >= 1), 16'h0001, "edge ignored");
    pin <= 1'b1;
    wait_idle();
    wr_reg(OFF_CONTROL_MAIN, 8'h00);
    $display("test edge_needed done");
  endtask : t_edge_needed

  task automatic t_channel();
    wr_reg(OFF_CHANNEL_CONTROL, 8'h4B);
    rd_reg(OFF_CONTROL_MAIN, r);
    check(16'(r[2:0]), 16'h0003, "mirror low bits");
    check(16'(channel_q), 16'h000B, "channel out");
    check(16'(input_select_q), 16'h0800, "second port select");
    wr_reg(OFF_CONTROL_MAIN, 8'h15);
    rd_reg(OFF_CHANNEL_CONTROL, r);
    check(16'(r), 16'h004D, "main write keeps top bit");
    rd_reg(OFF_CONTROL_MAIN, r);
    check(16'(r), 16'h0005, "busy write ignored");
    wr_reg(OFF_CHANNEL_CONTROL, 8'h4F);
    rd_reg(OFF_CHANNEL_CONTROL, r);
    check(16'(input_select_q), 16'h0000, "channel 15 none");
    wr_reg(OFF_CHANNEL_CONTROL, 8'h40);
    $display("test channel done");
  endtask : t_channel

  task automatic t_single();
    s = start_cnt;
    wr_reg(OFF_IRQ_ENABLE, 8'h01);
    wr_reg(OFF_RESULT_LOW, 8'hFF);
    #1;
    check(16'(conv_start_q), 16'h0001, "low write start");
    rd_reg(OFF_CONTROL_MAIN, r);
    check(16'(r[BIT_BUSY]), 16'h0001, "busy while running");
    wait_idle();
    check(16'(start_cnt), 16'(s + 1), "single count");
    rd_reg(OFF_RESULT_HIGH, r);
    check(16'(r), 16'(last_res[9:2]), "result high");
    rd_reg(OFF_RESULT_LOW, r);
    check(16'(r), 16'({last_res[1:0], 6'h00}), "result low");
    rd_reg(OFF_IRQ_REQUEST, r);
    check(16'(r[BIT_DONE_FLAG]), 16'h0001, "done flag");
    check(16'(irq_q), 16'h0001, "request raised");
    wr_reg(OFF_IRQ_REQUEST, 8'h00);
    cycles(2);
    check(16'(irq_q), 16'h0000, "request cleared");
    wr_reg(OFF_RESULT_HIGH, 8'hA5);
    rd_reg(OFF_RESULT_HIGH, r);
    check(16'(r), 16'h00A5, "high storage");
    rd_reg(OFF_RESULT_LOW, r);
    check(16'(r), 16'({last_res[1:0], 6'h00}), "low held");
    $display("test single done");
  endtask : t_single

  task automatic t_cont();
    slow <= 1'b0;
    wr_reg(OFF_CONTROL_MAIN, 8'h08);
    s = done_cnt;
    wr_reg(OFF_RESULT_LOW, 8'h00);
    for (int i = 0; i < 200 && done_cnt < s + 3; i++) @(posedge clk);
    check(16'(done_cnt >= s + 3), 16'h0001, "chained runs");
    slow <= 1'b1;
    wr_reg(OFF_CONTROL_MAIN, 8'h00);
    wait_idle();
    s = start_cnt;
    cycles(20);
    check(16'(start_cnt), 16'(s), "stopped after clear");
    check(16'(start_cnt), 16'(done_cnt), "last run finished");
    $display("test cont done");
  endtask : t_cont

  task automatic t_ext();
    slow <= 1'b0;
    wr_reg(OFF_CONTROL_MAIN, 8'h20);
    s = start_cnt;
    cycles(6);
    pin <= 1'b0;
    cycles(10);
    check(16'(start_cnt), 16'(s + 1), "pin fall start");
    cycles(30);
    check(16'(start_cnt), 16'(s + 1), "low level no repeat");
    pin <= 1'b1;
    wr_reg(OFF_CONTROL_MAIN, 8'h28);
    cycles(6);
    s = start_cnt;
    pin <= 1'b0;
    cycles(40);
    check(16'(start_cnt >= s + 4), 16'h0001, "runs while low");
    pin <= 1'b1;
    wait_idle();
    s = start_cnt;
    cycles(20);
    check(16'(start_cnt), 16'(s), "pin high stops");
    check(16'(start_cnt), 16'(done_cnt), "last run completes");
    wr_reg(OFF_CONTROL_MAIN, 8'h00);
    $display("test ext done");
  endtask : t_ext

  // a second reset with the pin held low: the release must not look like an edge
  task automatic t_reset_rearm();
    pin <= 1'b0;
    rst <= 1'b1;
    cycles(3);
    rst <= 1'b0;
    s = start_cnt;
    wr_reg(OFF_CONTROL_MAIN, 8'h20);
    cycles(20);
    check(16'(start_cnt), 16'(s), "false edge after reset");
    pin <= 1'b1;
    cycles(6);
    pin <= 1'b0;
    cycles(10);
    check(16'(start_cnt), 16'(s + 1), "edge after reset");
    pin <= 1'b1;
    wait_idle();
    wr_reg(OFF_CONTROL_MAIN, 8'h00);
    $display("test reset_rearm done");
  endtask : t_reset_rearm

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  // pin is low through reset so the first low level is not taken as an edge
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pin = 1'b0;
    slow = 1'b1;
    port7_pins = 8'hA6;
    port8_pins = 7'h35;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_edge_needed();
    t_channel();
    t_single();
    t_cont();
    t_ext();
    t_reset_rearm();
    summarize();
  end

  // the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    summarize();
  end

endmodule : tb_adc_conversion_control
